// *** verilog/root_hub_status_register.sv ***
/*
 * Root hub status register: hub-wide status, change flags, global power
 * command strobes and remote wakeup control, reached by command codes.
 * Assumes command inputs synchronous to i_clk and valid for one cycle;
 * per-port registers live elsewhere and feed mask, mode and connect change.
 */
// Summary of operation
// - Command 14h reads the register, command 94h writes it.
// - Low half holds hub status, high half holds matching change flags.
// - Writing one to bit 31 clears remote wake enable; zero does nothing.
// - Overcurrent change flag bit 17 sets whenever the overcurrent bit changes.
// - Writing one clears overcurrent change flag; zero has no effect.
// - Bits 16 and 0 always read zero.
// - Global mode: one to bit 16 powers all ports on.
// - Per-port mode: bit 16 powers on only unmasked ports.
// - Global mode: one to bit 0 powers all ports off.
// - Per-port mode: bit 0 powers off only unmasked ports.
// - With wake enabled, connect change resumes a suspended hub and interrupts.
// - With wake disabled, connect change is no wakeup event.
// - Writing one to bit 15 sets remote wake enable; zero does nothing.
// - Global reporting: bit 1 shows overcurrent present.
// - Per-port overcurrent protection holds bit 1 at zero.
// - Per-port mode: set mask bit keeps a port out of global power commands; global mode ignores the mask.
`timescale 1ns/1ps
module root_hub_status_register (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Command port.
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [31:0] i_wr_data,
  // Hub environment.
  input wire logic i_per_port_switching_select,
  input wire logic i_per_port_oc_select,
  input wire logic [rh_status_pkg::NUM_PORTS-1:0] i_port_power_ctl_mask,
  input wire logic i_overcurrent,
  input wire logic i_attach_change_flag,
  input wire logic i_suspend_req,
  input wire logic i_resume_done,
  // Read data and hub outputs.
  output logic [31:0] o_rd_data,
  output logic o_rd_valid,
  output logic [rh_status_pkg::NUM_PORTS-1:0] o_port_powered_flag,
  output logic o_resume_seen_interrupt,
  output logic [1:0] o_hub_state
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic wake_en_reg;
  logic oc_reg;
  logic oc_next;
  logic oc_chg_reg;
  logic [rh_status_pkg::NUM_PORTS-1:0] pwr_reg;
  logic [rh_status_pkg::NUM_PORTS-1:0] pwr_sel;
  logic [31:0] status_word;
  logic wr_en;
  logic rd_en;
  logic wake_event;
  rh_status_pkg::hub_state_t state_reg;

  // Reset release is synchronised so all flops behind the synchroniser leave reset on one edge.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // Command decode.
  assign rd_en = i_cmd_valid && (i_cmd_code == rh_status_pkg::CMD_READ);
  assign wr_en = i_cmd_valid && (i_cmd_code == rh_status_pkg::CMD_WRITE);

  // Overcurrent indication is forced low when reporting is per port.
  assign oc_next = i_overcurrent && !i_per_port_oc_select;

  // Ports steered by global commands: all in global mode, unmasked in per-port.
  assign pwr_sel = i_per_port_switching_select ? ~i_port_power_ctl_mask
                                               : {rh_status_pkg::NUM_PORTS{1'b1}};

  // Wakeup needs the enable flag and a suspended hub.
  assign wake_event = i_attach_change_flag && wake_en_reg
                      && (state_reg == rh_status_pkg::HUB_SUSPENDED);

  // Read image: strobes and local power bits read as zero, reserved as zero.
  always_comb
  begin
    status_word = rh_status_pkg::STATUS_RESET;
    status_word[rh_status_pkg::BIT_OC_CHANGE] = oc_chg_reg;
    status_word[rh_status_pkg::BIT_WAKE_EN] = wake_en_reg;
    status_word[rh_status_pkg::BIT_OC] = oc_reg;
  end

  // Remote wake enable: set by bit 15, cleared by bit 31; clear wins if both.
  always_ff @(posedge i_clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
      wake_en_reg <= 1'b0;
    else if (wr_en && i_wr_data[rh_status_pkg::BIT_WAKE_CLR])
      wake_en_reg <= 1'b0;
    else if (wr_en && i_wr_data[rh_status_pkg::BIT_WAKE_EN])
      wake_en_reg <= 1'b1;
  end

  // Overcurrent level and its sticky change flag; a new change beats the clear.
  always_ff @(posedge i_clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      oc_reg <= 1'b0;
      oc_chg_reg <= 1'b0;
    end
    else
    begin
      oc_reg <= oc_next;
      if (oc_next != oc_reg)
        oc_chg_reg <= 1'b1;
      else if (wr_en && i_wr_data[rh_status_pkg::BIT_OC_CHANGE])
        oc_chg_reg <= 1'b0;
    end
  end

  // Port power: write strobes act once; off wins if both bits are written.
  always_ff @(posedge i_clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
      pwr_reg <= rh_status_pkg::PORT_PWR_RESET;
    else if (wr_en && i_wr_data[rh_status_pkg::BIT_PWR_OFF])
      pwr_reg <= pwr_reg & ~pwr_sel;
    else if (wr_en && i_wr_data[rh_status_pkg::BIT_PWR_ON])
      pwr_reg <= pwr_reg | pwr_sel;
  end

  // Hub state: suspend on request, resume on wake event, back when done.
  always_ff @(posedge i_clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      state_reg <= rh_status_pkg::HUB_OPERATIONAL;
      o_resume_seen_interrupt <= 1'b0;
    end
    else
    begin
      o_resume_seen_interrupt <= wake_event;
      case (state_reg)
        rh_status_pkg::HUB_OPERATIONAL:
          if (i_suspend_req)
            state_reg <= rh_status_pkg::HUB_SUSPENDED;
        rh_status_pkg::HUB_SUSPENDED:
          if (wake_event)
            state_reg <= rh_status_pkg::HUB_RESUMING;
        rh_status_pkg::HUB_RESUMING:
          if (i_resume_done)
            state_reg <= rh_status_pkg::HUB_OPERATIONAL;
        default:
          state_reg <= rh_status_pkg::HUB_OPERATIONAL;
      endcase
    end
  end

  // Read answer registered one cycle after the read command.
  always_ff @(posedge i_clk or negedge rst_sync2_reg)
  begin
    if (!rst_sync2_reg)
    begin
      o_rd_data <= rh_status_pkg::STATUS_RESET;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= rd_en;
      if (rd_en)
        o_rd_data <= status_word;
    end
  end

  // Outputs are the flops themselves, so no logic sits after the last register.
  assign o_port_powered_flag = pwr_reg;
  assign o_hub_state = state_reg;

  // Assertions.
  property p_rd_answer;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    rd_en |=> o_rd_valid && (o_rd_data == $past(status_word));
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer wrong");

  property p_zero_bits;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    o_rd_valid |-> (o_rd_data[31:18] == 14'h0000) && (o_rd_data[14:2] == 13'h0000)
      && !o_rd_data[rh_status_pkg::BIT_PWR_ON] && !o_rd_data[rh_status_pkg::BIT_PWR_OFF];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("zero bits read one");

  property p_wake_clr;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_wr_data[rh_status_pkg::BIT_WAKE_CLR] |=> !wake_en_reg;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake not cleared");

  property p_wake_set;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_wr_data[rh_status_pkg::BIT_WAKE_EN] && !i_wr_data[rh_status_pkg::BIT_WAKE_CLR]
      |=> wake_en_reg;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake not set");

  property p_oc_change;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    (oc_next != oc_reg) |=> oc_chg_reg;
  endproperty
  a_oc_change: assert property (p_oc_change) else $error("oc change missed");

  property p_oc_perport;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    i_per_port_oc_select |=> !oc_reg;
  endproperty
  a_oc_perport: assert property (p_oc_perport) else $error("oc not held low");

  property p_pwr_on;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_wr_data[rh_status_pkg::BIT_PWR_ON] && !i_wr_data[rh_status_pkg::BIT_PWR_OFF]
      |=> ((pwr_reg & $past(pwr_sel)) == $past(pwr_sel));
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power on failed");

  property p_pwr_masked;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_per_port_switching_select |=>
      ((pwr_reg & $past(i_port_power_ctl_mask)) == ($past(pwr_reg) & $past(i_port_power_ctl_mask)));
  endproperty
  a_pwr_masked: assert property (p_pwr_masked) else $error("masked port changed");

  property p_no_wake;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    !wake_en_reg |=> !o_resume_seen_interrupt;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake while disabled");

  // Read data must hold and the valid pulse stay low between reads.
  property p_rd_quiet;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    !rd_en |=> !o_rd_valid && (o_rd_data == $past(o_rd_data));
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved");

  // Zeros in both wake bits leave the wake flag alone.
  property p_wake_hold;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    !(wr_en && (i_wr_data[rh_status_pkg::BIT_WAKE_CLR]
      || i_wr_data[rh_status_pkg::BIT_WAKE_EN])) |=> (wake_en_reg == $past(wake_en_reg));
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake moved");

  // A clear only loses to a change that lands in the same cycle.
  property p_oc_clear;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_wr_data[rh_status_pkg::BIT_OC_CHANGE] && (oc_next == oc_reg) |=> !oc_chg_reg;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("oc change not cleared");

  property p_oc_hold;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    oc_chg_reg && !(wr_en && i_wr_data[rh_status_pkg::BIT_OC_CHANGE]) |=> oc_chg_reg;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("oc change lost");

  // With global reporting the status bit follows the overcurrent input.
  property p_oc_level;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    !i_per_port_oc_select |=> (oc_reg == $past(i_overcurrent));
  endproperty
  a_oc_level: assert property (p_oc_level) else $error("oc level wrong");

  // In global mode, power-off commands reach every port regardless of the mask.
  property p_pwr_off;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && !i_per_port_switching_select && i_wr_data[rh_status_pkg::BIT_PWR_OFF]
      |=> (pwr_reg == '0);
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power off failed");

  // Per-port mode: unmasked ports follow the command, masked ports are checked above.
  property p_pwr_on_pp;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_per_port_switching_select && i_wr_data[rh_status_pkg::BIT_PWR_ON]
      && !i_wr_data[rh_status_pkg::BIT_PWR_OFF]
      |=> ((pwr_reg | $past(i_port_power_ctl_mask)) == {rh_status_pkg::NUM_PORTS{1'b1}});
  endproperty
  a_pwr_on_pp: assert property (p_pwr_on_pp) else $error("per-port on failed");

  property p_pwr_off_pp;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wr_en && i_per_port_switching_select && i_wr_data[rh_status_pkg::BIT_PWR_OFF]
      |=> ((pwr_reg & ~$past(i_port_power_ctl_mask)) == '0);
  endproperty
  a_pwr_off_pp: assert property (p_pwr_off_pp) else $error("port off failed");

  // Power strobes are not stored, so without one the port power must hold.
  property p_pwr_hold;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    !(wr_en && (i_wr_data[rh_status_pkg::BIT_PWR_ON]
      || i_wr_data[rh_status_pkg::BIT_PWR_OFF])) |=> (pwr_reg == $past(pwr_reg));
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power moved");

  // An enabled wake event must both interrupt and start the resume.
  property p_wake_resume;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    wake_event |=> o_resume_seen_interrupt && (state_reg == rh_status_pkg::HUB_RESUMING);
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("no resume");

  property p_no_wake_state;
    @(posedge i_clk) disable iff (!rst_sync2_reg)
    (state_reg == rh_status_pkg::HUB_SUSPENDED) && !wake_en_reg
      |=> (state_reg == rh_status_pkg::HUB_SUSPENDED);
  endproperty
  a_no_wake_state: assert property (p_no_wake_state) else $error("left suspend");
endmodule : root_hub_status_register

// *** verilog/rh_status_pkg.sv ***
/*
 * Package for the root hub status register block: command codes, bit
 * positions, reset values and the hub state encoding.
 * Assumes a single controller clock domain and no external bus.
 */
package rh_status_pkg;
  localparam logic [7:0] CMD_READ = 8'h14;
  localparam logic [7:0] CMD_WRITE = 8'h94;
  localparam int BIT_WAKE_CLR = 31;
  localparam int BIT_OC_CHANGE = 17;
  localparam int BIT_PWR_ON = 16;
  localparam int BIT_WAKE_EN = 15;
  localparam int BIT_OC = 1;
  localparam int BIT_PWR_OFF = 0;
  localparam int NUM_PORTS = 2;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [NUM_PORTS-1:0] PORT_PWR_RESET = 2'h0;
  typedef enum logic [1:0] {
    HUB_OPERATIONAL,
    HUB_SUSPENDED,
    HUB_RESUMING
  } hub_state_t;
endpackage : rh_status_pkg

// *** tb/root_hub_status_register_bench.sv ***
/*
 * Self-checking bench for the root hub status register: command decode, wake
 * flag, power strobes, overcurrent flags and the wake-driven resume path.
 * Assumes the design samples inputs on rising i_clk and syncs i_nrst itself.
 */
`timescale 1ns/1ps
module root_hub_status_register_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd_code = 8'h00;
  logic [31:0] i_wr_data = 32'h00000000;
  logic sel = 1'b0;
  logic ocsel = 1'b0;
  logic [1:0] mask = 2'h0;
  logic oc = 1'b0;
  logic att = 1'b0;
  logic susp = 1'b0;
  logic rdone = 1'b0;
  logic [31:0] o_rd_data;
  logic o_rd_valid;
  logic [1:0] pw;
  logic irq;
  logic [1:0] st;
  logic [31:0] rdv;
  int bad_count = 0;
  int tests_run = 0;

  root_hub_status_register i_root_hub_status_register (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_code(i_cmd_code), .i_wr_data(i_wr_data),
    .i_per_port_switching_select(sel), .i_per_port_oc_select(ocsel),
    .i_port_power_ctl_mask(mask), .i_overcurrent(oc), .i_attach_change_flag(att),
    .i_suspend_req(susp), .i_resume_done(rdone), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_port_powered_flag(pw),
    .o_resume_seen_interrupt(irq), .o_hub_state(st));

  // A 5 ns period gives the 200 MHz controller clock.
  always #2.5 i_clk = ~i_clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // One command cycle; the result is looked at on the falling edge, once settled.
  task cmd(input logic [7:0] code, input logic [31:0] data);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_code <= code;
    i_wr_data <= data;
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    @(negedge i_clk);
    rdv = o_rd_data;
  endtask : cmd

  // Every value written by the scenarios keeps the reserved bits at zero.
  task wr(input logic [31:0] data);
    cmd(rh_status_pkg::CMD_WRITE, data);
  endtask : wr

  task rd;
    cmd(rh_status_pkg::CMD_READ, 32'h00000000);
    chk(o_rd_valid, 1'b1);
  endtask : rd

  task env(input logic m, input logic [1:0] k);
    @(posedge i_clk);
    sel <= m;
    mask <= k;
  endtask : env

  // Foreign codes must neither answer nor write.
  task t_access;
    rd();
    chk(rdv, rh_status_pkg::STATUS_RESET);
    cmd(8'h15, 32'h00000000);
    chk(o_rd_valid, 1'b0);
    cmd(8'h13, 32'h00008000);
    chk(o_rd_valid, 1'b0);
    cmd(8'h95, 32'h00008000);
    rd();
    chk(rdv, 32'h00000000);
  endtask : t_access

  task t_wake;
    wr(32'h00008000);
    wr(32'h00000000);
    rd();
    chk(rdv, 32'h00008000);
    wr(32'h80000000);
    rd();
    chk(rdv, 32'h00000000);
    wr(32'h00008000);
    wr(32'h80008000);
    rd();
    chk(rdv, 32'h00000000);
  endtask : t_wake

  task t_power;
    wr(32'h00010000);
    chk(pw, 2'h3);
    rd();
    chk(rdv, 32'h00000000);
    wr(32'h00000000);
    chk(pw, 2'h3);
    wr(32'h00000001);
    chk(pw, 2'h0);
    env(1'b1, 2'h1);
    wr(32'h00010000);
    chk(pw, 2'h2);
    env(1'b1, 2'h0);
    wr(32'h00010000);
    env(1'b1, 2'h2);
    wr(32'h00000001);
    chk(pw, 2'h2);
    env(1'b0, 2'h2);
    wr(32'h00000001);
    chk(pw, 2'h0);
  endtask : t_power

  task t_oc;
    @(posedge i_clk);
    oc <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd();
    chk(rdv, 32'h00020002);
    wr(32'h00000000);
    rd();
    chk(rdv, 32'h00020002);
    wr(32'h00020000);
    rd();
    chk(rdv, 32'h00000002);
    @(posedge i_clk);
    oc <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd();
    chk(rdv, 32'h00020000);
    wr(32'h00020000);
    @(posedge i_clk);
    ocsel <= 1'b1;
    oc <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd();
    chk(rdv, 32'h00000000);
  endtask : t_oc

  // Attach change wakes the suspended hub only with the wake flag set.
  task t_resume;
    @(posedge i_clk);
    susp <= 1'b1;
    @(posedge i_clk);
    susp <= 1'b0;
    att <= 1'b1;
    @(posedge i_clk);
    att <= 1'b0;
    @(negedge i_clk);
    chk(irq, 1'b0);
    chk(st, rh_status_pkg::HUB_SUSPENDED);
    wr(32'h00008000);
    @(posedge i_clk);
    att <= 1'b1;
    @(posedge i_clk);
    att <= 1'b0;
    @(negedge i_clk);
    chk(irq, 1'b1);
    chk(st, rh_status_pkg::HUB_RESUMING);
    @(posedge i_clk);
    rdone <= 1'b1;
    @(negedge i_clk);
    chk(irq, 1'b0);
    @(posedge i_clk);
    rdone <= 1'b0;
    @(negedge i_clk);
    chk(st, rh_status_pkg::HUB_OPERATIONAL);
  endtask : t_resume

  // A mid-run reset must drop power and wake state back to reset values.
  task t_reset;
    wr(32'h00018000);
    chk(pw, 2'h3);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    @(negedge i_clk);
    chk(pw, rh_status_pkg::PORT_PWR_RESET);
    chk(o_rd_valid, 1'b0);
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd();
    chk(rdv, rh_status_pkg::STATUS_RESET);
  endtask : t_reset

  task test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // The sequence takes under 150 cycles; the 20 us limit leaves wide slack.
  initial
  begin
    #20000;
    bad_count++;
    test_done();
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_access();
    t_wake();
    t_power();
    t_oc();
    t_resume();
    t_reset();
    test_done();
  end
endmodule : root_hub_status_register_bench
